/* design/dasalu_consts.vh */
`ifndef DASALU_CONSTS_VH
`define DASALU_CONSTS_VH
// Instruction fields
`define DASALU_OPC_HI 31
`define DASALU_OPC_LO 26
`define DASALU_SRC1_HI 25
`define DASALU_SRC1_LO 21
`define DASALU_SRC2_HI 20
`define DASALU_SRC2_LO 16
`define DASALU_DST_HI 15
`define DASALU_DST_LO 11
`define DASALU_SA_HI 10
`define DASALU_SA_LO 6
`define DASALU_FN_HI 5
`define DASALU_FN_LO 0
// Primary opcodes
`define DASALU_OPC_SPECIAL 6'h00
`define DASALU_OPC_ADD_CONST 6'h19
// Function codes under the special opcode
`define DASALU_FN_SHL_VAR 6'h14
`define DASALU_FN_DIV_S 6'h1A
`define DASALU_FN_DIV_U 6'h1B
`define DASALU_FN_ADD_REG 6'h2D
`define DASALU_FN_SHL_FIX 6'h38
`define DASALU_FN_SHL_FIX32 6'h3C
`define DASALU_FN_READ_REM 6'h10
`define DASALU_FN_READ_QUO 6'h12
// Divider
`define DASALU_DIV_STEPS 6'h20
`define DASALU_MOST_NEG 32'h80000000
`define DASALU_MINUS_ONE 32'hFFFFFFFF
`endif

/* design/dasalu_core.v */
// Notes on behaviour
// - Constant add: sign-extend 16-bit immediate, add to source one, write source-two slot.
// - Neither non-trapping add ever raises overflow; wrapped sum is written.
// - Register add: sum both 64-bit sources modulo 2^64 into destination.
// - Signed divide of low 32 bits: quotient and remainder to result registers.
// - Quotient and remainder written as 32-bit values sign-extended to 64 bits.
// - No arithmetic exception from either divide, even zero divisor or overflow.
// - Most negative divided by minus one gives most negative, remainder zero.
// - Divide runs in background; reads of result registers stall until written.
// - Divides use low 32 operand bits only; upper bits ignored.
// - Unsigned divide treats low 32 bits of both sources as unsigned.
// - Fixed left shift by 0..31, zero fill, write destination.
// - Fixed left shift plus 32 covers 32..63, zero fill.
// - Variable left shift by low six bits of source one, zero fill.
// - Constant add is primary opcode 011001 with fields 25..21, 20..16, 15..0.
`timescale 1ns/1ns
`default_nettype none
`include "dasalu_consts.vh"

module dasalu_core #(
    parameter WIDTH = 64,
    parameter WORD = 32
) (
    input wire clk,
    input wire reset_n,
    input wire issueValid,
    input wire [31:0] instruction,
    input wire [WIDTH-1:0] sourceOperandOne,
    input wire [WIDTH-1:0] sourceOperandTwo,
    output reg issueStall,
    output reg writeValid,
    output reg [4:0] writeIndex,
    output reg [WIDTH-1:0] writeData,
    output reg overflowTrap,
    output reg divideBusy,
    output reg [WIDTH-1:0] quotientResultReg,
    output reg [WIDTH-1:0] remainderResultReg
);

    wire [5:0] opcode;
    wire [5:0] funct;
    wire [4:0] srcTwoIdx;
    wire [4:0] dstIdx;
    wire [4:0] shiftAmountField;
    wire [15:0] immediate;
    wire isSpecial;
    wire opAddConst;
    wire opAddReg;
    wire opShlFix;
    wire opShlFix32;
    wire opShlVar;
    wire opDivS;
    wire opDivU;
    wire opReadQuo;
    wire opReadRem;
    wire opDivide;
    wire readStall;
    wire [WIDTH-1:0] immExt;
    wire [WIDTH-1:0] addConstSum;
    wire [WIDTH-1:0] addRegSum;
    wire [5:0] varCount;
    wire [WIDTH-1:0] shlFix;
    wire [WIDTH-1:0] shlFix32;
    wire [WIDTH-1:0] shlVar;
    wire [WORD-1:0] dividendWord;
    wire [WORD-1:0] divisorWord;
    wire dividendNeg;
    wire divisorNeg;
    wire [WORD-1:0] dividendMag;
    wire [WORD-1:0] divisorMag;
    wire [WORD:0] trial;
    wire [WORD-1:0] finalQuo;
    wire [WORD-1:0] finalRem;

    reg [WORD-1:0] divQuo;
    reg [WORD-1:0] divRem;
    reg [WORD-1:0] divDivisor;
    reg [5:0] divCount;
    reg negQuo;
    reg negRem;

    assign opcode = instruction[`DASALU_OPC_HI:`DASALU_OPC_LO];
    assign funct = instruction[`DASALU_FN_HI:`DASALU_FN_LO];
    assign srcTwoIdx = instruction[`DASALU_SRC2_HI:`DASALU_SRC2_LO];
    assign dstIdx = instruction[`DASALU_DST_HI:`DASALU_DST_LO];
    assign shiftAmountField = instruction[`DASALU_SA_HI:`DASALU_SA_LO];
    assign immediate = instruction[15:0];

    assign isSpecial = opcode == `DASALU_OPC_SPECIAL;
    assign opAddConst = issueValid && opcode == `DASALU_OPC_ADD_CONST;
    assign opAddReg = issueValid && isSpecial && funct == `DASALU_FN_ADD_REG;
    assign opShlFix = issueValid && isSpecial && funct == `DASALU_FN_SHL_FIX;
    assign opShlFix32 = issueValid && isSpecial && funct == `DASALU_FN_SHL_FIX32;
    assign opShlVar = issueValid && isSpecial && funct == `DASALU_FN_SHL_VAR;
    assign opDivS = issueValid && isSpecial && funct == `DASALU_FN_DIV_S;
    assign opDivU = issueValid && isSpecial && funct == `DASALU_FN_DIV_U;
    assign opReadQuo = issueValid && isSpecial && funct == `DASALU_FN_READ_QUO;
    assign opReadRem = issueValid && isSpecial && funct == `DASALU_FN_READ_REM;
    assign opDivide = opDivS || opDivU;

    // Reads of the result registers, or a new divide, wait for the running divide
    assign readStall = divideBusy && (opReadQuo || opReadRem || opDivide);

    assign immExt = {{(WIDTH-16){immediate[15]}}, immediate};
    assign addConstSum = sourceOperandOne + immExt;
    assign addRegSum = sourceOperandOne + sourceOperandTwo;

    assign shlFix = sourceOperandTwo << shiftAmountField;
    assign shlFix32 = sourceOperandTwo << {1'b1, shiftAmountField};
    assign varCount = sourceOperandOne[5:0];
    assign shlVar = sourceOperandTwo << varCount;

    // Only the low word takes part in a divide
    assign dividendWord = sourceOperandOne[WORD-1:0];
    assign divisorWord = sourceOperandTwo[WORD-1:0];
    assign dividendNeg = opDivS && dividendWord[WORD-1];
    assign divisorNeg = opDivS && divisorWord[WORD-1];
    assign dividendMag = dividendNeg ? (~dividendWord + 1'b1) : dividendWord;
    assign divisorMag = divisorNeg ? (~divisorWord + 1'b1) : divisorWord;

    // Restoring division step: shift in next dividend bit, subtract if it fits
    assign trial = {divRem, divQuo[WORD-1]} - {1'b0, divDivisor};
    // Magnitudes are signed back: truncation toward zero, remainder follows dividend
    assign finalQuo = negQuo ? (~divQuo + 1'b1) : divQuo;
    assign finalRem = negRem ? (~divRem + 1'b1) : divRem;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            issueStall <= 1'b0;
            writeValid <= 1'b0;
            writeIndex <= 5'h00;
            writeData <= {WIDTH{1'b0}};
            overflowTrap <= 1'b0;
        end else begin
            issueStall <= readStall;
            overflowTrap <= 1'b0;
            writeValid <= 1'b0;
            if (!readStall) begin
                if (opAddConst) begin
                    writeValid <= 1'b1;
                    writeIndex <= srcTwoIdx;
                    writeData <= addConstSum;
                end else if (opAddReg) begin
                    writeValid <= 1'b1;
                    writeIndex <= dstIdx;
                    writeData <= addRegSum;
                end else if (opShlFix) begin
                    writeValid <= 1'b1;
                    writeIndex <= dstIdx;
                    writeData <= shlFix;
                end else if (opShlFix32) begin
                    writeValid <= 1'b1;
                    writeIndex <= dstIdx;
                    writeData <= shlFix32;
                end else if (opShlVar) begin
                    writeValid <= 1'b1;
                    writeIndex <= dstIdx;
                    writeData <= shlVar;
                end else if (opReadQuo) begin
                    writeValid <= 1'b1;
                    writeIndex <= dstIdx;
                    writeData <= quotientResultReg;
                end else if (opReadRem) begin
                    writeValid <= 1'b1;
                    writeIndex <= dstIdx;
                    writeData <= remainderResultReg;
                end
            end
        end
    end

    // Background divider; later unrelated instructions keep issuing
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divideBusy <= 1'b0;
            divCount <= 6'h00;
            divQuo <= {WORD{1'b0}};
            divRem <= {WORD{1'b0}};
            divDivisor <= {WORD{1'b0}};
            negQuo <= 1'b0;
            negRem <= 1'b0;
            quotientResultReg <= {WIDTH{1'b0}};
            remainderResultReg <= {WIDTH{1'b0}};
        end else if (!divideBusy) begin
            if (opDivide) begin
                divideBusy <= 1'b1;
                divCount <= `DASALU_DIV_STEPS;
                divQuo <= dividendMag;
                divRem <= {WORD{1'b0}};
                divDivisor <= divisorMag;
                negQuo <= dividendNeg ^ divisorNeg;
                negRem <= dividendNeg;
            end
        end else if (divCount != 6'h00) begin
            // A zero divisor just runs out with an all-ones quotient, no trap
            divCount <= divCount - 6'h01;
            if (!trial[WORD]) begin
                divRem <= trial[WORD-1:0];
                divQuo <= {divQuo[WORD-2:0], 1'b1};
            end else begin
                divRem <= {divRem[WORD-2:0], divQuo[WORD-1]};
                divQuo <= {divQuo[WORD-2:0], 1'b0};
            end
        end else begin
            // Most negative over minus one wraps to most negative, remainder zero
            divideBusy <= 1'b0;
            quotientResultReg <= {{(WIDTH-WORD){finalQuo[WORD-1]}}, finalQuo};
            remainderResultReg <= {{(WIDTH-WORD){finalRem[WORD-1]}}, finalRem};
        end
    end

endmodule // dasalu_core

`default_nettype wire

/* bench/dasalu_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dasalu_consts.vh"
module dasalu_chk (
    input wire logic clk, reset_n, issueValid, issueStall, writeValid, overflowTrap, divideBusy,
    input wire logic [31:0] instruction,
    input wire logic [4:0] writeIndex,
    input wire logic [63:0] sourceOperandOne, sourceOperandTwo, writeData, quotientResultReg, remainderResultReg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic sp = issueValid && instruction[31:26] == `DASALU_OPC_SPECIAL;
    wire logic [5:0] fn = instruction[5:0];
    a_never_trap:
        assert property (!overflowTrap) else $error("trap raised");
    a_const_add:
        assert property (issueValid && instruction[31:26] == `DASALU_OPC_ADD_CONST |=> writeValid && writeIndex ==
            $past(instruction[20:16]) && writeData == $past(sourceOperandOne) + 64'($signed($past(instruction[15:0]))))
            else $error("bad const add");
    a_reg_add:
        assert property (sp && fn == `DASALU_FN_ADD_REG |=>
            writeData == $past(sourceOperandOne) + $past(sourceOperandTwo)) else $error("bad reg add");
    a_fixed_shift:
        assert property (sp && fn == `DASALU_FN_SHL_FIX |=>
            writeData == $past(sourceOperandTwo) << $past(instruction[10:6])) else $error("bad shift");
    a_variable_shift:
        assert property (sp && fn == `DASALU_FN_SHL_VAR |=>
            writeData == $past(sourceOperandTwo) << $past(sourceOperandOne[5:0])) else $error("bad var shift");
    a_divide_busy:
        assert property (sp && !divideBusy && (fn | 6'h01) == `DASALU_FN_DIV_U |=> divideBusy[*8] ##[20:40] !divideBusy)
            else $error("bad divide timing");
    a_read_stall:
        assert property (sp && divideBusy && (fn | 6'h02) == `DASALU_FN_READ_QUO |=> issueStall && !writeValid)
            else $error("read not stalled");
    a_result_sext:
        assert property ($fell(divideBusy) |-> quotientResultReg[63:31] == {33{quotientResultReg[31]}}
            && remainderResultReg[63:31] == {33{remainderResultReg[31]}}) else $error("result not extended");
endmodule // dasalu_chk
bind dasalu_core dasalu_chk u_chk (.clk, .reset_n, .issueValid, .issueStall, .writeValid, .overflowTrap, .divideBusy,
    .instruction, .writeIndex, .sourceOperandOne, .sourceOperandTwo, .writeData, .quotientResultReg, .remainderResultReg);
`default_nettype wire

/* bench/dasalu_regfile_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dasalu_regfile_model (
    input wire logic clk, writeValid,
    input wire logic [4:0] writeIndex,
    input wire logic [31:0] instruction,
    input wire logic [63:0] writeData,
    output logic [63:0] sourceOperandOne, sourceOperandTwo
);
    logic [63:0] regs [0:31];
    assign sourceOperandOne = regs[instruction[25:21]];
    assign sourceOperandTwo = regs[instruction[20:16]];
    always @(posedge clk) begin
        if (writeValid)
            regs[writeIndex] <= writeData;
    end
endmodule // dasalu_regfile_model
`default_nettype wire

/* bench/test_dword_add_divide_shift_alu.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dasalu_consts.vh"
module test_dword_add_divide_shift_alu;
    typedef struct {logic [31:0] ins; logic [63:0] a, b, e;} dasalu_row_t;
    localparam logic [63:0] pat = 64'h0123456789ABCDEF;
    logic clk = 1'b0, reset_n = 1'b0, issueValid = 1'b0;
    logic [31:0] instruction = 32'h0;
    wire logic writeValid, divideBusy;
    wire logic [4:0] writeIndex;
    wire logic [63:0] opOne, opTwo, writeData, quo, rem;
    int errors = 0, samples_checked = 0, cycles = 0;
    dasalu_row_t rows [9];
    always #5 clk = ~clk;
    dasalu_regfile_model u_rf (.clk, .writeValid, .writeIndex, .instruction, .writeData,
        .sourceOperandOne(opOne), .sourceOperandTwo(opTwo));
    dasalu_core u_dut (.clk, .reset_n, .issueValid, .instruction, .sourceOperandOne(opOne), .sourceOperandTwo(opTwo),
        .issueStall(), .writeValid, .writeIndex, .writeData, .overflowTrap(), .divideBusy,
        .quotientResultReg(quo), .remainderResultReg(rem));
    function automatic logic [31:0] sp(input logic [5:0] fn, input logic [4:0] sa);
        return {`DASALU_OPC_SPECIAL, 15'h0443, sa, fn};
    endfunction
    task automatic chk(input string name, input logic [63:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Held while stalled; released once the write or the divide start shows
    task automatic issue(input logic [31:0] ins, input logic [63:0] a, b);
        @(negedge clk);
        u_rf.regs[1] = a;
        u_rf.regs[2] = b;
        instruction = ins;
        issueValid = 1'b1;
        for (int n = 0; n < 60 && !writeValid && !(divideBusy && (ins[5:0] | 6'h01) == `DASALU_FN_DIV_U); n++)
            @(negedge clk);
        issueValid = 1'b0;
        @(negedge clk);
    endtask
    task automatic dv(input logic [5:0] fn, input logic [63:0] a, b, q, r);
        issue(sp(fn, 5'h00), a, b);
        for (int n = 0; n < 40 && divideBusy; n++)
            @(negedge clk);
        chk("quotient", q, quo);
        chk("remainder", r, rem);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        rows = '{'{{`DASALU_OPC_ADD_CONST, 26'h0220001}, 64'h7FFFFFFFFFFFFFFF, 64'h0, 64'h8000000000000000},
            '{{`DASALU_OPC_ADD_CONST, 26'h0228000}, 64'h5, 64'h0, 64'hFFFFFFFFFFFF8005},
            '{sp(`DASALU_FN_ADD_REG, 5'h00), '1, 64'h2, 64'h1},
            '{sp(`DASALU_FN_SHL_FIX, 5'h00), 64'h0, pat, pat},
            '{sp(`DASALU_FN_SHL_FIX, 5'h1F), 64'h0, pat, pat << 31},
            '{sp(`DASALU_FN_SHL_FIX32, 5'h00), 64'h0, pat, pat << 32},
            '{sp(`DASALU_FN_SHL_FIX32, 5'h1F), 64'h0, pat, pat << 63},
            '{sp(`DASALU_FN_SHL_VAR, 5'h00), 64'hFFC0, pat, pat},
            '{sp(`DASALU_FN_SHL_VAR, 5'h00), 64'h7F, pat, pat << 63}};
        repeat (16) @(negedge clk);
        chk("reset outputs", 64'h0, quo | rem | writeData | {62'h0, writeValid, divideBusy});
        reset_n = 1'b1;
        // Constant add writes the source-two slot, the others slot 3
        foreach (rows[i]) begin
            issue(rows[i].ins, rows[i].a, rows[i].b);
            chk("row result", rows[i].e, u_rf.regs[3 - rows[i].ins[30]]);
        end
        dv(`DASALU_FN_DIV_S, 64'h12345678FFFFFFF9, 64'hABCD000000000002, 64'hFFFFFFFFFFFFFFFD, '1);
        dv(`DASALU_FN_DIV_S, 64'h80000000, 64'hFFFFFFFF, 64'hFFFFFFFF80000000, 64'h0);
        dv(`DASALU_FN_DIV_U, 64'hFFFFFFFE, 64'h1, 64'hFFFFFFFFFFFFFFFE, 64'h0);
        issue(sp(`DASALU_FN_DIV_S, 5'h00), 64'h64, 64'h7);
        issue(sp(`DASALU_FN_ADD_REG, 5'h00), 64'h3, 64'h4);
        chk("add during divide", 64'h7, u_rf.regs[3]);
        issue(sp(`DASALU_FN_READ_QUO, 5'h00), 64'h0, 64'h0);
        chk("stalled read", 64'hE, u_rf.regs[3]);
        issue(sp(`DASALU_FN_READ_REM, 5'h00), 64'h0, 64'h0);
        chk("remainder read", 64'h2, u_rf.regs[3]);
        issue(sp(`DASALU_FN_DIV_U, 5'h00), 64'h5, 64'h0);
        issue(sp(`DASALU_FN_READ_REM, 5'h00), 64'h0, 64'h0);
        close_out();
    end
endmodule // test_dword_add_divide_shift_alu
`default_nettype wire
